// *** tb_usb_power_path_control.sv ***
// Purpose: self-checking bench for the usb power path control block
// Assumes: supply levels given as millivolt codes, demand in tenths of a milliamp
// Notes: expected limits are kept in a local table, not taken from the design
`timescale 1ns/1ps
module tb_usb_power_path_control;
  import uppc_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk_sys;
  logic reset;
  logic [17:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  uppc_levels_t levels;
  logic battery_present, system_supply_low, otp_valid, start_request, in_backup;
  logic [2:0] otp_usb_limit_sel;
  uppc_src_t source_sel;
  logic battery_supplement, usb_switch_open, buck_ldo_mode, ldo_current_limit;
  logic trickle_charge, start_grant, rtc_clock_enable, power_path_primary_irq;
  int error_cnt;
  int tests_run;
  // usb limit per code, tenths of a milliamp
  logic [15:0] lim_tab [8] = '{16'h0000, 16'h0019, 16'h03E8, 16'h1388, 16'h2328, 16'h3A98, 16'h4650, 16'h157C};

  uppc_top uppc_top_inst (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .levels(levels), .battery_present(battery_present),
    .system_supply_low(system_supply_low), .otp_valid(otp_valid), .otp_usb_limit_sel(otp_usb_limit_sel),
    .start_request(start_request), .in_backup(in_backup), .source_sel(source_sel),
    .battery_supplement(battery_supplement), .usb_switch_open(usb_switch_open), .buck_ldo_mode(buck_ldo_mode),
    .ldo_current_limit(ldo_current_limit), .trickle_charge(trickle_charge), .start_grant(start_grant),
    .rtc_clock_enable(rtc_clock_enable), .power_path_primary_irq(power_path_primary_irq));

  // ------------------------------------------------------------
  // clock, verdict and watchdog
  // ------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // run needs about 290 cycles; allow some forty times that
  initial
  begin
    #100000;
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    stop_test();
  end

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until the edge that sees waitrequest low; an idle edge follows release
  task automatic bus(input logic wr, input logic [17:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    avs_address <= addr;
    avs_writedata <= data;
    avs_read <= !wr;
    avs_write <= wr;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      error_cnt++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [17:0] addr, input logic [31:0] data);
    bus(1'b1, addr, data);
  endtask

  task automatic rd_chk(input logic [17:0] addr, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0000_0000);
    check(rd & mask, exp);
  endtask

  task automatic lv(input logic [15:0] u, input logic [15:0] w, input logic [15:0] b, input logic [15:0] d);
    levels <= {u, w, b, d};
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic req(input logic on);
    start_request <= on;
    repeat (4) @(posedge clk_sys);
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    error_cnt = 0;
    tests_run = 0;
    reset = 1'b1;
    avs_address = 18'h00000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    levels = '0;
    battery_present = 1'b0;
    system_supply_low = 1'b0;
    otp_valid = 1'b0;
    otp_usb_limit_sel = 3'h0;
    start_request = 1'b0;
    in_backup = 1'b0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd_chk(UPPC_ADDR_SETUP, 32'hFFFF_FFFF, 32'h0000_0002);
    rd_chk(UPPC_ADDR_MASKS, 32'h0000_E000, 32'h0000_E000);
    rd_chk(18'h00100, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test reset done");
    otp_usb_limit_sel <= 3'h4;
    otp_valid <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd_chk(UPPC_ADDR_SETUP, 32'h0000_0007, 32'h0000_0004);
    wr(UPPC_ADDR_SETUP, 32'h0000_000F);
    // status bit 3 is read-only, the limit stays writable after the load
    rd_chk(UPPC_ADDR_SETUP, 32'h0000_000F, 32'h0000_0007);
    $display("test limit load done");
    battery_present <= 1'b1;
    lv(16'h1388, 16'h0000, 16'h0E74, 16'h0000);
    check({30'h0, source_sel}, {30'h0, UPPC_SRC_USB});
    rd_chk(UPPC_ADDR_SETUP, 32'h0000_0300, 32'h0000_0100);
    lv(16'h0FA0, 16'h0BB8, 16'h0E10, 16'h0000);
    check({30'h0, source_sel}, {30'h0, UPPC_SRC_USB});
    lv(16'h1388, 16'h1388, 16'h0E74, 16'h0000);
    check({30'h0, source_sel}, {30'h0, UPPC_SRC_WALL});
    rd_chk(UPPC_ADDR_SETUP, 32'h0000_0300, 32'h0000_0300);
    $display("test source select done");
    for (int i = 0; i < 8; i++)
    begin
      wr(UPPC_ADDR_SETUP, {29'h0, 3'(i)});
      lv(16'h1388, 16'h0000, 16'h0E74, lim_tab[i] + 16'h0001);
      rd_chk(UPPC_ADDR_SETUP, 32'h0000_0008, 32'h0000_0008);
      check({31'h0, battery_supplement}, 32'h0000_0001);
      check({31'h0, usb_switch_open}, {31'h0, i == 0});
      lv(16'h1388, 16'h0000, 16'h0E74, lim_tab[i]);
      rd_chk(UPPC_ADDR_SETUP, 32'h0000_0008, 32'h0000_0000);
    end
    $display("test usb limit done");
    rd_chk(UPPC_ADDR_FLAGS, 32'h0000_E000, 32'h0000_6000);
    check({31'h0, power_path_primary_irq}, 32'h0000_0000);
    wr(UPPC_ADDR_MASKS, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    check({31'h0, power_path_primary_irq}, 32'h0000_0001);
    wr(UPPC_ADDR_FLAGS, 32'h0000_4000);
    rd_chk(UPPC_ADDR_FLAGS, 32'h0000_E000, 32'h0000_2000);
    wr(UPPC_ADDR_FLAGS, 32'h0000_2000);
    repeat (2) @(posedge clk_sys);
    check({31'h0, power_path_primary_irq}, 32'h0000_0000);
    system_supply_low <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd_chk(UPPC_ADDR_FLAGS, 32'h0000_E000, 32'h0000_8000);
    // level still high: no new edge, so the clear must stick
    wr(UPPC_ADDR_FLAGS, 32'h0000_8000);
    rd_chk(UPPC_ADDR_FLAGS, 32'h0000_E000, 32'h0000_0000);
    system_supply_low <= 1'b0;
    wr(UPPC_ADDR_MASKS, 32'h0000_8000);
    system_supply_low <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({31'h0, power_path_primary_irq}, 32'h0000_0000);
    system_supply_low <= 1'b0;
    $display("test interrupts done");
    // every on request below is made with the limit at 100ma
    wr(UPPC_ADDR_SETUP, 32'h0000_0012);
    req(1'b1);
    check({30'h0, buck_ldo_mode, ldo_current_limit}, 32'h0000_0003);
    req(1'b0);
    wr(UPPC_ADDR_SETUP, 32'h0000_0002);
    req(1'b1);
    check({30'h0, start_grant, buck_ldo_mode}, 32'h0000_0002);
    req(1'b0);
    wr(UPPC_ADDR_CTRL, 32'h0000_0001);
    wr(UPPC_ADDR_SETUP, 32'h0000_0022);
    lv(16'h1388, 16'h0000, 16'h0BB8, 16'h0000);
    req(1'b1);
    check({30'h0, start_grant, trickle_charge}, 32'h0000_0001);
    lv(16'h1388, 16'h0000, 16'h0C80, 16'h0000);
    check({31'h0, start_grant}, 32'h0000_0001);
    req(1'b0);
    wr(UPPC_ADDR_CTRL, 32'h0000_0000);
    wr(UPPC_ADDR_SETUP, 32'h0000_0032);
    req(1'b1);
    check({30'h0, start_grant, trickle_charge}, 32'h0000_0000);
    lv(16'h1388, 16'h0000, 16'h0DAC, 16'h0000);
    check({31'h0, start_grant}, 32'h0000_0001);
    req(1'b0);
    $display("test start-up done");
    in_backup <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({31'h0, rtc_clock_enable}, 32'h0000_0000);
    wr(UPPC_ADDR_CTRL, 32'h0000_0002);
    repeat (3) @(posedge clk_sys);
    check({31'h0, rtc_clock_enable}, 32'h0000_0001);
    $display("test backup done");
    stop_test();
  end
endmodule // tb_usb_power_path_control

// *** uppc_pkg.sv ***
// Purpose: constants and types for the usb power path control block
// Assumes: one clock, synchronous active-high reset, avalon-mm register access
// Notes: printed offsets are register indices; byte address is four times the index
package uppc_pkg;
  // ------------------------------------------------------------
  // register indices and byte addresses
  // ------------------------------------------------------------
  localparam logic [15:0] UPPC_IDX_SETUP = 16'h4003;
  localparam logic [15:0] UPPC_IDX_FLAGS = 16'h4011;
  localparam logic [15:0] UPPC_IDX_MASKS = 16'h4019;
  localparam logic [15:0] UPPC_IDX_CTRL = 16'h4020;
  localparam logic [17:0] UPPC_ADDR_SETUP = {UPPC_IDX_SETUP, 2'b00};
  localparam logic [17:0] UPPC_ADDR_FLAGS = {UPPC_IDX_FLAGS, 2'b00};
  localparam logic [17:0] UPPC_ADDR_MASKS = {UPPC_IDX_MASKS, 2'b00};
  localparam logic [17:0] UPPC_ADDR_CTRL = {UPPC_IDX_CTRL, 2'b00};
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int UPPC_LIM_LSB = 0;
  localparam int UPPC_HIT_BIT = 3;
  localparam int UPPC_MODE_LSB = 4;
  localparam int UPPC_WALL_BIT = 9;
  localparam int UPPC_USB_BIT = 8;
  localparam int UPPC_IRQ_UV_BIT = 15;
  localparam int UPPC_IRQ_SRC_BIT = 14;
  localparam int UPPC_IRQ_LIM_BIT = 13;
  localparam int UPPC_CHG_BIT = 0;
  localparam int UPPC_XTAL_BIT = 1;
  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [2:0] UPPC_LIM_RESET = 3'h2;
  localparam logic [2:0] UPPC_LIM_OPEN = 3'h0;
  localparam logic [2:0] UPPC_LIM_100MA = 3'h2;
  localparam logic [1:0] UPPC_MODE_RESET = 2'h0;
  localparam logic [2:0] UPPC_MASK_RESET = 3'h7;
  localparam logic [15:0] UPPC_UNMAPPED_DATA = 16'h0000;
  // supply levels in millivolts, compared against 16-bit monitor codes
  localparam logic [15:0] UPPC_MV_NORM_LO = 16'd4300;
  localparam logic [15:0] UPPC_MV_NORM_HI = 16'd5500;
  localparam logic [15:0] UPPC_MV_WALL_LOW = 16'd3400;
  localparam logic [15:0] UPPC_MV_BATT_31 = 16'd3100;
  localparam logic [15:0] UPPC_MV_BATT_34 = 16'd3400;
  // limit in milliamps x10 per code (2.5mA -> 25)
  localparam logic [15:0] UPPC_LIMIT_TAB [8] = '{16'd0, 16'd25, 16'd1000, 16'd5000,
    16'd9000, 16'd15000, 16'd18000, 16'd5500};

  typedef enum logic [1:0]
  {
    UPPC_MODE_NORMAL = 2'b00,
    UPPC_MODE_SOFT = 2'b01,
    UPPC_MODE_BATT31 = 2'b10,
    UPPC_MODE_BATT34 = 2'b11
  } uppc_mode_t;

  typedef enum logic [1:0]
  {
    UPPC_SRC_BATT = 2'b00,
    UPPC_SRC_WALL = 2'b01,
    UPPC_SRC_USB = 2'b10
  } uppc_src_t;

  typedef enum logic [1:0]
  {
    UPPC_ST_IDLE = 2'b00,
    UPPC_ST_WAIT = 2'b01,
    UPPC_ST_GRANT = 2'b10
  } uppc_start_t;

  typedef struct packed
  {
    logic [15:0] usb_mv;
    logic [15:0] wall_mv;
    logic [15:0] batt_mv;
    logic [15:0] demand_ma10;
  } uppc_levels_t;

  typedef struct packed
  {
    logic undervolt;
    logic source_change;
    logic usb_limit;
  } uppc_irq_t;
endpackage

// *** uppc_top.sv ***
// Operation
// - pick usb when usb in 4.3-5.5v, wall below 4.3v, usb highest
// - pick usb below 4.3v when wall under 3.4v and usb highest
// - three-bit usb limit, reset 010, codes map to eight current limits
// - demand above limit while on usb sets limit-hit status and usb limit flag
// - on usb, draw battery supplement so usb current stays within limit
// - suitable wall supply appearing during usb operation takes over as source
// - limit loads from otp at start-up and stays software writable
// - two-bit start-up mode in bits 5:4 for 100ma usb start-up
// - soft-start enables bucks in ldo mode and current-limits ldos
// - battery-threshold modes hold start request, trickle only if charger enabled
// - undervoltage flag bit 15 sets on rising edge of supply-low
// - source-change flag bit 14 sets on wall or usb status change
// - flags set on rising edge (bit 14 on either edge of a status change) and clear only on written one
// - unmasked set flag drives primary interrupt; mask one suppresses it
// - mask bits 15:13 reset to one
// - in backup, stop rtc when crystal backup enable is zero
// - wall-present and usb-present read one when source available
//
// Purpose: usb branch of the power path: source choice, usb limit, start-up gating, irqs
// Assumes: supply levels arrive as digital codes synchronous to clk_sys
// Notes: analog regulation is outside; this block only issues the control levels
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
module uppc_top
  import uppc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // supply monitor
  input wire uppc_levels_t levels,
  input wire logic battery_present,
  input wire logic system_supply_low,
  input wire logic otp_valid,
  input wire logic [2:0] otp_usb_limit_sel,
  // power state
  input wire logic start_request,
  input wire logic in_backup,
  // control outputs
  output uppc_src_t source_sel,
  output logic battery_supplement,
  output logic usb_switch_open,
  output logic buck_ldo_mode,
  output logic ldo_current_limit,
  output logic trickle_charge,
  output logic start_grant,
  output logic rtc_clock_enable,
  output logic power_path_primary_irq
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [2:0] usb_limit_sel_q, usb_limit_sel_d;
  logic [1:0] low_limit_startup_mode_q, low_limit_startup_mode_d;
  uppc_irq_t flags_q, flags_d;
  uppc_irq_t masks_q, masks_d;
  logic charger_enable_q, charger_enable_d;
  logic crystal_backup_enable_q, crystal_backup_enable_d;
  logic otp_done_q, otp_done_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic wait_q, wait_d;
  // ------------------------------------------------------------
  // live status and edge history
  // ------------------------------------------------------------
  logic wall_present_q, wall_present_d;
  logic usb_present_q, usb_present_d;
  logic usb_limit_hit_status_q, usb_limit_hit_status_d;
  logic low_q, low_d;
  uppc_src_t source_q, source_d;
  logic supp_q, supp_d;
  logic open_q, open_d;
  logic bucks_q, bucks_d;
  logic ldol_q, ldol_d;
  logic trkl_q, trkl_d;
  logic grant_q, grant_d;
  logic rtc_q, rtc_d;
  logic irq_q, irq_d;
  uppc_start_t st_q, st_d;

  logic wall_norm, wall_ok, usb_norm, usb_highest, usb_pick, wall_pick;
  logic over_limit, batt_ok, low_start;
  logic acc, wr_hit_setup, wr_hit_flags, wr_hit_masks, wr_hit_ctrl;
  uppc_irq_t rise;
  logic [15:0] limit_now;

  // ------------------------------------------------------------
  // source arbitration
  // ------------------------------------------------------------
  always_comb
  begin
    wall_norm = (levels.wall_mv >= UPPC_MV_NORM_LO) && (levels.wall_mv <= UPPC_MV_NORM_HI);
    usb_norm = (levels.usb_mv >= UPPC_MV_NORM_LO) && (levels.usb_mv <= UPPC_MV_NORM_HI);
    usb_highest = (levels.usb_mv > levels.wall_mv) && (levels.usb_mv > levels.batt_mv);
    wall_ok = (levels.wall_mv > levels.batt_mv) && (wall_norm || (levels.usb_mv < UPPC_MV_NORM_LO));
    usb_pick = usb_highest && ((usb_norm && (levels.wall_mv < UPPC_MV_NORM_LO))
      || ((levels.usb_mv < UPPC_MV_NORM_LO) && (levels.wall_mv < UPPC_MV_WALL_LOW)));
    // wall wins whenever suitable and usb is not picked, even mid-usb operation
    wall_pick = wall_ok && !usb_pick;
    source_d = wall_pick ? UPPC_SRC_WALL : (usb_pick ? UPPC_SRC_USB : UPPC_SRC_BATT);
    wall_present_d = wall_ok;
    // usb counts as present whenever it could power the device, even while wall is chosen
    usb_present_d = usb_pick || usb_norm;
    limit_now = UPPC_LIMIT_TAB[usb_limit_sel_q];
    over_limit = (source_q == UPPC_SRC_USB) && (levels.demand_ma10 > limit_now);
    usb_limit_hit_status_d = over_limit;
    supp_d = over_limit && battery_present;
    open_d = (usb_limit_sel_q == UPPC_LIM_OPEN);
    low_d = system_supply_low;
  end

  // ------------------------------------------------------------
  // start-up gating
  // ------------------------------------------------------------
  always_comb
  begin
    // a limit below 100ma is the caller's fault; start is still attempted
    low_start = (source_q == UPPC_SRC_USB) && (usb_limit_sel_q == UPPC_LIM_100MA);
    case (low_limit_startup_mode_q)
      UPPC_MODE_BATT31: batt_ok = levels.batt_mv > UPPC_MV_BATT_31;
      UPPC_MODE_BATT34: batt_ok = levels.batt_mv > UPPC_MV_BATT_34;
      default: batt_ok = 1'b1;
    endcase
    st_d = st_q;
    grant_d = 1'b0;
    trkl_d = 1'b0;
    bucks_d = bucks_q;
    ldol_d = ldol_q;
    case (st_q)
      UPPC_ST_IDLE:
      begin
        bucks_d = 1'b0;
        ldol_d = 1'b0;
        if (start_request)
        begin
          st_d = UPPC_ST_WAIT;
        end
      end
      UPPC_ST_WAIT:
      begin
        if (!low_start || batt_ok)
        begin
          st_d = UPPC_ST_GRANT;
          grant_d = 1'b1;
          bucks_d = low_start && (low_limit_startup_mode_q == UPPC_MODE_SOFT);
          ldol_d = low_start && (low_limit_startup_mode_q == UPPC_MODE_SOFT);
        end
        else
        begin
          trkl_d = charger_enable_q;
        end
      end
      UPPC_ST_GRANT:
      begin
        grant_d = 1'b1;
        if (!start_request)
        begin
          st_d = UPPC_ST_IDLE;
        end
      end
      default: st_d = UPPC_ST_IDLE;
    endcase
    rtc_d = !(in_backup && !crystal_backup_enable_q);
  end

  // ------------------------------------------------------------
  // register bus and interrupts
  // ------------------------------------------------------------
  always_comb
  begin
    acc = (avs_read || avs_write) && !ack_q;
    // writes land at the edge where waitrequest is seen low, as the master expects
    wr_hit_setup = ack_q && avs_write && (avs_address == UPPC_ADDR_SETUP);
    wr_hit_flags = ack_q && avs_write && (avs_address == UPPC_ADDR_FLAGS);
    wr_hit_masks = ack_q && avs_write && (avs_address == UPPC_ADDR_MASKS);
    wr_hit_ctrl = ack_q && avs_write && (avs_address == UPPC_ADDR_CTRL);
    usb_limit_sel_d = usb_limit_sel_q;
    low_limit_startup_mode_d = low_limit_startup_mode_q;
    otp_done_d = otp_done_q;
    if (!otp_done_q && otp_valid)
    begin
      usb_limit_sel_d = otp_usb_limit_sel;
      otp_done_d = 1'b1;
    end
    else if (wr_hit_setup)
    begin
      usb_limit_sel_d = avs_writedata[UPPC_LIM_LSB +: 3];
      low_limit_startup_mode_d = avs_writedata[UPPC_MODE_LSB +: 2];
    end
    rise.undervolt = system_supply_low && !low_q;
    rise.source_change = (wall_present_d != wall_present_q) || (usb_present_d != usb_present_q);
    rise.usb_limit = over_limit && !usb_limit_hit_status_q;
    flags_d = flags_q;
    if (wr_hit_flags)
    begin
      flags_d = flags_q & ~uppc_irq_t'(avs_writedata[UPPC_IRQ_LIM_BIT +: 3]);
    end
    flags_d = flags_d | rise;
    masks_d = wr_hit_masks ? uppc_irq_t'(avs_writedata[UPPC_IRQ_LIM_BIT +: 3]) : masks_q;
    charger_enable_d = wr_hit_ctrl ? avs_writedata[UPPC_CHG_BIT] : charger_enable_q;
    crystal_backup_enable_d = wr_hit_ctrl ? avs_writedata[UPPC_XTAL_BIT] : crystal_backup_enable_q;
    irq_d = |(flags_q & ~masks_q);
    ack_d = acc;
    wait_d = !acc;
    rdata_d = 32'h0000_0000;
    if (acc && avs_read)
    begin
      case (avs_address)
        UPPC_ADDR_SETUP: rdata_d = {16'h0000, 6'h00, wall_present_q, usb_present_q, 2'h0,
          low_limit_startup_mode_q, usb_limit_hit_status_q, usb_limit_sel_q};
        UPPC_ADDR_FLAGS: rdata_d = {16'h0000, flags_q, 13'h0000};
        UPPC_ADDR_MASKS: rdata_d = {16'h0000, masks_q, 13'h0000};
        UPPC_ADDR_CTRL: rdata_d = {30'h0000_0000, crystal_backup_enable_q, charger_enable_q};
        default: rdata_d = {16'h0000, UPPC_UNMAPPED_DATA};
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      usb_limit_sel_q <= UPPC_LIM_RESET;
      low_limit_startup_mode_q <= UPPC_MODE_RESET;
      flags_q <= '0;
      masks_q <= UPPC_MASK_RESET;
      charger_enable_q <= 1'b0;
      crystal_backup_enable_q <= 1'b0;
      otp_done_q <= 1'b0;
      rdata_q <= '0;
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      wall_present_q <= 1'b0;
      usb_present_q <= 1'b0;
      usb_limit_hit_status_q <= 1'b0;
      low_q <= 1'b0;
      source_q <= UPPC_SRC_BATT;
      supp_q <= 1'b0;
      open_q <= 1'b0;
      bucks_q <= 1'b0;
      ldol_q <= 1'b0;
      trkl_q <= 1'b0;
      grant_q <= 1'b0;
      rtc_q <= 1'b1;
      irq_q <= 1'b0;
      st_q <= UPPC_ST_IDLE;
    end
    else
    begin
      usb_limit_sel_q <= usb_limit_sel_d;
      low_limit_startup_mode_q <= low_limit_startup_mode_d;
      flags_q <= flags_d;
      masks_q <= masks_d;
      charger_enable_q <= charger_enable_d;
      crystal_backup_enable_q <= crystal_backup_enable_d;
      otp_done_q <= otp_done_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      wait_q <= wait_d;
      wall_present_q <= wall_present_d;
      usb_present_q <= usb_present_d;
      usb_limit_hit_status_q <= usb_limit_hit_status_d;
      low_q <= low_d;
      source_q <= source_d;
      supp_q <= supp_d;
      open_q <= open_d;
      bucks_q <= bucks_d;
      ldol_q <= ldol_d;
      trkl_q <= trkl_d;
      grant_q <= grant_d;
      rtc_q <= rtc_d;
      irq_q <= irq_d;
      st_q <= st_d;
    end
  end

  // waitrequest drops in the cycle after a request is seen, one-cycle answer
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign source_sel = source_q;
  assign battery_supplement = supp_q;
  assign usb_switch_open = open_q;
  assign buck_ldo_mode = bucks_q;
  assign ldo_current_limit = ldol_q;
  assign trickle_charge = trkl_q;
  assign start_grant = grant_q;
  assign rtc_clock_enable = rtc_q;
  assign power_path_primary_irq = irq_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  uv_flag_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(system_supply_low) |=> flags_q.undervolt) else $error("undervolt flag not set");
  flag_w1c_a: assert property (@(posedge clk_sys) disable iff (reset)
    (flags_q.usb_limit && !wr_hit_flags) |=> flags_q.usb_limit) else $error("flag lost without clear");
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 (power_path_primary_irq == $past(|(flags_q & ~masks_q)))) else $error("primary irq mismatch");
  hit_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(usb_limit_hit_status_q) |-> flags_q.usb_limit) else $error("limit flag not raised");
  hit_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
    !over_limit |=> !usb_limit_hit_status_q) else $error("limit status stuck");
  rtc_stop_a: assert property (@(posedge clk_sys) disable iff (reset)
    (in_backup && !crystal_backup_enable_q) |=> !rtc_clock_enable) else $error("rtc not stopped");
  batt_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (st_q == UPPC_ST_WAIT && low_start && !batt_ok) |=> (!start_grant && trickle_charge == $past(charger_enable_q)))
    else $error("start not held");
  wall_over_a: assert property (@(posedge clk_sys) disable iff (reset)
    (source_q == UPPC_SRC_USB && wall_pick) |=> source_sel == UPPC_SRC_WALL) else $error("wall not taken");
  supp_a: assert property (@(posedge clk_sys) disable iff (reset)
    (over_limit && battery_present) |=> battery_supplement) else $error("no battery supplement");
  src_chg_a: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(usb_present_q) |-> flags_q.source_change) else $error("source flag not set");
  cv_grant_c: cover property (@(posedge clk_sys) disable iff (reset) $rose(start_grant));
  cv_soft_c: cover property (@(posedge clk_sys) disable iff (reset) $rose(buck_ldo_mode));
  cv_irq_c: cover property (@(posedge clk_sys) disable iff (reset) $rose(power_path_primary_irq));
endmodule // uppc_top
